// [hdl/pmsc_top.sv]
// Power-management status and control register with Avalon-MM access
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
module pmsc_top (
  // Clock and power-on reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Any other reset, synchronous pulse or level
  input  wire logic                          sys_rst_req,
  // Avalon-MM slave
  input  wire logic [pmsc_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [pmsc_pkg::DATA_W/8-1:0] avs_byteenable,
  input  wire logic [pmsc_pkg::DATA_W-1:0]   avs_writedata,
  output logic      [pmsc_pkg::DATA_W-1:0]   avs_readdata,
  output logic                               avs_waitrequest,
  // Comparator and power controller inputs
  input  wire logic                          supply_below_warn,
  input  wire logic                          ppd_wake,
  // Threshold and stop mode controls
  output logic                               detect_threshold_select,
  output logic                               warning_threshold_select,
  output logic                               deep_stop_mode_select,
  // Interrupt
  output logic                               irq
);
  import pmsc_pkg::*;

  localparam int unsigned PAD_CTRL = DATA_W - REG_W;
  localparam int unsigned PAD_IRQ  = DATA_W - IRQ_W;

  logic              warn_lvl;
  logic              wake_lvl;
  logic              req_start;
  logic              acc_rd;
  logic              acc_wr;
  logic              wr_ctl;
  logic              wr_mask;
  logic              rd_stat;
  logic              rd_ctl_start;
  logic              wake_rise;
  logic              wd_ack;
  logic              wd_det;
  logic              wd_wsel;
  logic              wd_ppd_ack;
  logic              wd_mode;
  logic              flag_ff;
  logic              nxt_flag;
  logic              det_ff;
  logic              nxt_det;
  logic              wsel_ff;
  logic              nxt_wsel;
  logic              ppd_ff;
  logic              nxt_ppd;
  logic              mode_ff;
  logic              nxt_mode;
  logic              lock_ff;
  logic              nxt_lock;
  logic              wake_prev_ff;
  logic [IRQ_W-1:0]  stat_ff;
  logic [IRQ_W-1:0]  nxt_stat;
  logic [IRQ_W-1:0]  mask_ff;
  logic [IRQ_W-1:0]  nxt_mask;
  logic [IRQ_W-1:0]  snap_ff;
  logic [IRQ_W-1:0]  nxt_snap;
  logic [IRQ_W-1:0]  events;
  logic              irq_ff;
  logic              nxt_irq;
  logic [REG_W-1:0]  ctrl_view;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  // Comparator and wake inputs cross into the clock domain
  pmsc_sync3 #(
    .W (2)
  ) u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .async_in  ({ppd_wake, supply_below_warn}),
    .level_out ({wake_lvl, warn_lvl})
  );

  // Bus handshake
  pmsc_avmm u_avmm (
    .clk             (clk),
    .rst_n           (rst_n),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_waitrequest (avs_waitrequest),
    .req_start       (req_start),
    .acc_rd          (acc_rd),
    .acc_wr          (acc_wr)
  );

  // Decoded strobes and write data fields
  assign wr_ctl       = acc_wr && avs_byteenable[0] && addr_hit(avs_address, OFS_CTRL);
  assign wr_mask      = acc_wr && avs_byteenable[0] && addr_hit(avs_address, OFS_IRQ_MASK);
  assign rd_stat      = acc_rd && addr_hit(avs_address, OFS_IRQ_STAT);
  assign rd_ctl_start = req_start && avs_read && addr_hit(avs_address, OFS_CTRL);
  assign wake_rise    = wake_lvl && !wake_prev_ff;
  assign wd_ack       = avs_writedata[BIT_WARN_ACK];
  assign wd_det       = avs_writedata[BIT_DET_SEL];
  assign wd_wsel      = avs_writedata[BIT_WARN_SEL];
  assign wd_ppd_ack   = avs_writedata[BIT_PPD_ACK];
  assign wd_mode      = avs_writedata[BIT_MODE];

  // Control register next state
  always_comb begin
    nxt_flag = flag_ff;
    nxt_det  = det_ff;
    nxt_wsel = wsel_ff;
    nxt_ppd  = ppd_ff;
    nxt_mode = mode_ff;
    nxt_lock = lock_ff;
    if (sys_rst_req) begin
      nxt_flag = RST_BIT;
      nxt_ppd  = RST_BIT;
      nxt_mode = RST_BIT;
      nxt_lock = RST_BIT;
    end else begin
      if (wr_ctl) begin
        nxt_det  = wd_det;
        nxt_wsel = wd_wsel;
        if (wd_ack && !warn_lvl) begin
          nxt_flag = 1'b0;
        end
        if (wd_ppd_ack) begin
          nxt_ppd = 1'b0;
        end
        if (!lock_ff) begin
          nxt_mode = wd_mode;
          nxt_lock = 1'b1;
        end
      end
      // Hardware set wins over any acknowledge
      if (warn_lvl) begin
        nxt_flag = 1'b1;
      end
      if (wake_rise) begin
        nxt_ppd = 1'b1;
      end
    end
  end

  // Interrupt status, mask and read capture next state
  always_comb begin
    events           = '0;
    events[IRQ_WARN] = nxt_flag && !flag_ff;
    events[IRQ_PPD]  = nxt_ppd && !ppd_ff;
    nxt_stat         = stat_ff;
    nxt_mask         = mask_ff;
    nxt_snap         = snap_ff;
    if (rd_stat) begin
      nxt_stat = stat_ff & ~snap_ff;
    end
    nxt_stat = nxt_stat | events;
    if (wr_mask) begin
      nxt_mask = avs_writedata[IRQ_W-1:0];
    end
    if (sys_rst_req) begin
      nxt_stat = RST_IRQ;
      nxt_mask = RST_IRQ;
    end
    nxt_irq = |(nxt_stat & nxt_mask);
    // Control view: reserved and acknowledge bits read zero
    ctrl_view                = '0;
    ctrl_view[BIT_WARN_FLAG] = flag_ff;
    ctrl_view[BIT_DET_SEL]   = det_ff;
    ctrl_view[BIT_WARN_SEL]  = wsel_ff;
    ctrl_view[BIT_PPD_FLAG]  = ppd_ff;
    ctrl_view[BIT_MODE]      = mode_ff;
    nxt_rdata                = rdata_ff;
    if (req_start && avs_read) begin
      nxt_rdata = '0;
      if (addr_hit(avs_address, OFS_CTRL)) begin
        nxt_rdata = {{PAD_CTRL{1'b0}}, ctrl_view};
      end else if (addr_hit(avs_address, OFS_IRQ_STAT)) begin
        nxt_rdata = {{PAD_IRQ{1'b0}}, stat_ff};
        nxt_snap  = stat_ff;
      end else if (addr_hit(avs_address, OFS_IRQ_MASK)) begin
        nxt_rdata = {{PAD_IRQ{1'b0}}, mask_ff};
      end
    end
  end

  // Register all state; power-on reset clears everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff      <= RST_BIT;
      det_ff       <= RST_BIT;
      wsel_ff      <= RST_BIT;
      ppd_ff       <= RST_BIT;
      mode_ff      <= RST_BIT;
      lock_ff      <= RST_BIT;
      wake_prev_ff <= RST_BIT;
      stat_ff      <= RST_IRQ;
      mask_ff      <= RST_IRQ;
      snap_ff      <= RST_IRQ;
      irq_ff       <= RST_BIT;
      rdata_ff     <= '0;
    end else begin
      flag_ff      <= nxt_flag;
      det_ff       <= nxt_det;
      wsel_ff      <= nxt_wsel;
      ppd_ff       <= nxt_ppd;
      mode_ff      <= nxt_mode;
      lock_ff      <= nxt_lock;
      wake_prev_ff <= wake_lvl;
      stat_ff      <= nxt_stat;
      mask_ff      <= nxt_mask;
      snap_ff      <= nxt_snap;
      irq_ff       <= nxt_irq;
      rdata_ff     <= nxt_rdata;
    end
  end

  // Outputs straight from flops
  assign avs_readdata             = rdata_ff;
  assign detect_threshold_select  = det_ff;
  assign warning_threshold_select = wsel_ff;
  assign deep_stop_mode_select    = mode_ff;
  assign irq                      = irq_ff;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_warn_set:
    assert property (warn_lvl && !sys_rst_req |=> flag_ff)
    else $error("warning flag not set while below threshold");

  chk_flag_read:
    assert property (rd_ctl_start |=> avs_readdata[BIT_WARN_FLAG] == $past(flag_ff))
    else $error("warning flag read back wrong");

  chk_ack_clear:
    assert property (wr_ctl && wd_ack && !warn_lvl && !sys_rst_req |=> !flag_ff)
    else $error("warning acknowledge did not clear flag");

  chk_ack_bits_zero:
    assert property (rd_ctl_start |=> avs_readdata[BIT_WARN_ACK] == 1'b0
                     && avs_readdata[BIT_PPD_ACK] == 1'b0 && avs_readdata[1] == 1'b0)
    else $error("write-only or reserved bit read nonzero");

  chk_det_write:
    assert property (wr_ctl && !sys_rst_req |=> det_ff == $past(wd_det))
    else $error("detect threshold select not written");

  chk_wsel_write:
    assert property (wr_ctl && !sys_rst_req |=> wsel_ff == $past(wd_wsel))
    else $error("warning threshold select not written");

  chk_ppd_set:
    assert property (wake_rise && !sys_rst_req |=> ppd_ff)
    else $error("recovery flag not set on wake");

  chk_ppd_ack:
    assert property (wr_ctl && wd_ppd_ack && !wake_rise && !sys_rst_req |=> !ppd_ff)
    else $error("recovery acknowledge did not clear flag");

  chk_mode_first:
    assert property (wr_ctl && !lock_ff && !sys_rst_req
                     |=> mode_ff == $past(wd_mode) && lock_ff)
    else $error("first stop mode write not taken");

  chk_mode_locked:
    assert property (lock_ff && !sys_rst_req |=> $stable(mode_ff) && lock_ff)
    else $error("stop mode changed after first write");

  chk_soft_reset:
    assert property (sys_rst_req |=> !ppd_ff && !mode_ff && !lock_ff
                     && $stable(det_ff) && $stable(wsel_ff))
    else $error("other reset handled wrongly");

  chk_irq_level:
    assert property (rst_n |-> irq == |(stat_ff & mask_ff))
    else $error("interrupt output disagrees with status and mask");

endmodule

// [hdl/pmsc_pkg.sv]
// Shared constants and helpers of the power-management status and control block
package pmsc_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned IRQ_W  = 2;

  // Byte offsets of the registers
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;

  // Field positions of the control register
  localparam int unsigned BIT_WARN_FLAG = 7;
  localparam int unsigned BIT_WARN_ACK  = 6;
  localparam int unsigned BIT_DET_SEL   = 5;
  localparam int unsigned BIT_WARN_SEL  = 4;
  localparam int unsigned BIT_PPD_FLAG  = 3;
  localparam int unsigned BIT_PPD_ACK   = 2;
  localparam int unsigned BIT_MODE      = 0;

  // Field positions of the interrupt status and mask registers
  localparam int unsigned IRQ_WARN = 0;
  localparam int unsigned IRQ_PPD  = 1;

  // Reset values
  localparam logic             RST_BIT  = 1'b0;
  localparam logic [IRQ_W-1:0] RST_IRQ  = 2'h0;
  localparam logic             RST_WAIT = 1'b1;

  // Bus handshake states
  typedef enum logic {
    PMSC_BUS_IDLE,
    PMSC_BUS_ANSWER
  } pmsc_bus_t;

  // Address match against one register offset
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

endpackage

// [hdl/pmsc_sync3.sv]
// Three-stage input synchroniser with agreement filter
module pmsc_sync3 #(
  parameter int unsigned W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous inputs and filtered levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);
  import pmsc_pkg::*;

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // Level moves only once stages two and three agree
  always_comb begin
    nxt_out = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & out_ff);
  end

  // Synchroniser chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end else begin
      s1_ff  <= async_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign level_out = out_ff;

endmodule

// [hdl/pmsc_avmm.sv]
// Avalon-MM handshake: one wait cycle, then a one-cycle answer
module pmsc_avmm (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bus request
  input  wire logic avs_read,
  input  wire logic avs_write,
  output logic      avs_waitrequest,
  // Strobes to the register file
  output logic      req_start,
  output logic      acc_rd,
  output logic      acc_wr
);
  import pmsc_pkg::*;

  pmsc_bus_t state_ff;
  pmsc_bus_t nxt_state;
  logic      wait_ff;
  logic      nxt_wait;

  // Request seen in idle, answered in the next cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PMSC_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_state = PMSC_BUS_ANSWER;
        end
      end
      PMSC_BUS_ANSWER: begin
        nxt_state = PMSC_BUS_IDLE;
      end
      default: begin
        nxt_state = PMSC_BUS_IDLE;
      end
    endcase
    nxt_wait = (nxt_state != PMSC_BUS_ANSWER);
  end

  // Handshake state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= PMSC_BUS_IDLE;
      wait_ff  <= RST_WAIT;
    end else begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
    end
  end

  // Strobes for capture and for the accepting edge
  assign req_start       = (avs_read || avs_write) && (state_ff == PMSC_BUS_IDLE);
  assign acc_rd          = avs_read && (state_ff == PMSC_BUS_ANSWER);
  assign acc_wr          = avs_write && (state_ff == PMSC_BUS_ANSWER);
  assign avs_waitrequest = wait_ff;

endmodule

// [tb/pmsc_top_tb_top.sv]
// Self-checking testbench of the power-management status and control block
module pmsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pmsc_pkg::*;

  // Design ports
  logic                clk;
  logic                rst_n;
  logic                sys_rst_req;
  logic [ADDR_W-1:0]   avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [DATA_W/8-1:0] avs_byteenable;
  logic [DATA_W-1:0]   avs_writedata;
  logic [DATA_W-1:0]   avs_readdata;
  logic                avs_waitrequest;
  logic                supply_below_warn;
  logic                ppd_wake;
  logic                det_sel;
  logic                warn_sel;
  logic                mode_sel;
  logic                irq;
  // Bench state and expected register contents
  int                  num_errors;
  int                  tests_run;
  int                  seed;
  logic [DATA_W-1:0]   rd;
  logic [REG_W-1:0]    r;
  logic                m_det, m_warn, m_mode, m_lock, m_wf, m_ppd;

  pmsc_top uut (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .sys_rst_req              (sys_rst_req),
    .avs_address              (avs_address),
    .avs_read                 (avs_read),
    .avs_write                (avs_write),
    .avs_byteenable           (avs_byteenable),
    .avs_writedata            (avs_writedata),
    .avs_readdata             (avs_readdata),
    .avs_waitrequest          (avs_waitrequest),
    .supply_below_warn        (supply_below_warn),
    .ppd_wake                 (ppd_wake),
    .detect_threshold_select  (det_sel),
    .warning_threshold_select (warn_sel),
    .deep_stop_mode_select    (mode_sel),
    .irq                      (irq)
  );

  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Expected control register image
  function automatic logic [REG_W-1:0] exp_ctrl();
    return {m_wf, 1'b0, m_det, m_warn, m_ppd, 2'b00, m_mode};
  endfunction

  // One Avalon-MM transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    // Values seen here are those sampled at the edge; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    bus(1'b0, a, '0, 4'hf);
    check("readdata", exp, rd);
  endtask

  // Control write with the expected effects
  task automatic wr_ctrl(input logic [REG_W-1:0] d);
    bus(1'b1, OFS_CTRL, {24'h0, d}, 4'hf);
    m_det  = d[5];
    m_warn = d[4];
    if (!m_lock) m_mode = d[0];
    m_lock = 1'b1;
    if (d[2]) m_ppd = 1'b0;
    if (d[6] && !supply_below_warn) m_wf = 1'b0;
  endtask

  task automatic chk_outs();
    // Let the write landing at the last edge settle first
    @(negedge clk);
    check("detect select", {31'h0, m_det}, {31'h0, det_sel});
    check("warning select", {31'h0, m_warn}, {31'h0, warn_sel});
    check("stop mode select", {31'h0, m_mode}, {31'h0, mode_sel});
  endtask

  task automatic wake_pulse();
    @(posedge clk);
    ppd_wake <= 1'b1;
    repeat (5) @(posedge clk);
    ppd_wake <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Watchdog
  initial begin
    #(25 * 20000);
    num_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    {rst_n, sys_rst_req, avs_read, avs_write, supply_below_warn, ppd_wake} = '0;
    avs_address = '0;
    avs_byteenable = '0;
    avs_writedata = '0;
    {m_det, m_warn, m_mode, m_lock, m_wf, m_ppd} = '0;
    num_errors = 0;
    tests_run = 0;
    seed = 23;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check("waitrequest idle", 32'h1, {31'h0, avs_waitrequest});
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(4'hc, 32'h0);
    bus(1'b1, OFS_CTRL, 32'hff, 4'he);
    rd_chk(OFS_CTRL, 32'h0);
    // First write locks the stop mode, later ones move only thresholds
    r = REG_W'($random(seed));
    r[0] = 1'b1;
    wr_ctrl(r);
    for (int i = 0; i < 6; i++) begin
      r = REG_W'($random(seed));
      wr_ctrl(r);
      chk_outs();
      rd_chk(OFS_CTRL, {24'h0, exp_ctrl()});
    end
    // Warning flag: set, ack refused while present, sticky, then cleared
    bus(1'b1, OFS_IRQ_MASK, 32'h3, 4'hf);
    supply_below_warn <= 1'b1;
    repeat (8) @(posedge clk);
    m_wf = 1'b1;
    rd_chk(OFS_CTRL, {24'h0, exp_ctrl()});
    check("irq", 32'h1, {31'h0, irq});
    wr_ctrl(8'h40);
    rd_chk(OFS_CTRL, {24'h0, exp_ctrl()});
    supply_below_warn <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(OFS_CTRL, {24'h0, exp_ctrl()});
    wr_ctrl(8'h40);
    rd_chk(OFS_CTRL, {24'h0, exp_ctrl()});
    rd_chk(OFS_IRQ_STAT, 32'h1);
    rd_chk(OFS_IRQ_STAT, 32'h0);
    // Recovery flag with interrupt, clear on read, acknowledge
    wake_pulse();
    m_ppd = 1'b1;
    rd_chk(OFS_CTRL, {24'h0, exp_ctrl()});
    check("irq", 32'h1, {31'h0, irq});
    rd_chk(OFS_IRQ_STAT, 32'h2);
    repeat (2) @(negedge clk);
    check("irq", 32'h0, {31'h0, irq});
    wr_ctrl(8'h04);
    rd_chk(OFS_CTRL, {24'h0, exp_ctrl()});
    // Masked event stays off the interrupt line
    bus(1'b1, OFS_IRQ_MASK, 32'h0, 4'hf);
    wake_pulse();
    check("irq masked", 32'h0, {31'h0, irq});
    rd_chk(OFS_IRQ_STAT, 32'h2);
    wr_ctrl(8'h34);
    // Other reset keeps thresholds, warning re-sets while supply low
    supply_below_warn <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst_req <= 1'b1;
    @(posedge clk);
    sys_rst_req <= 1'b0;
    {m_mode, m_lock, m_ppd} = '0;
    m_wf = 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(OFS_CTRL, {24'h0, exp_ctrl()});
    chk_outs();
    rd_chk(OFS_IRQ_MASK, 32'h0);
    supply_below_warn <= 1'b0;
    repeat (8) @(posedge clk);
    wr_ctrl(8'h71);
    chk_outs();
    // Power-on reset clears the control register and the select outputs
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    {m_det, m_warn, m_mode, m_lock, m_wf, m_ppd} = '0;
    rd_chk(OFS_CTRL, 32'h0);
    chk_outs();
    complete_run();
  end
endmodule
